/* ckt_pkg.sv */
// constants and types shared by the clock tree files
`default_nettype none
package ckt_pkg;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_TUNING   = 12'hf9b;
  localparam logic [11:0] IDX_CONFIG   = 12'h000;
  localparam logic [11:0] IDX_FEATURE  = 12'h001;
  localparam logic [11:0] IDX_OSC_CTRL = 12'h002;
  localparam logic [11:0] IDX_STATUS   = 12'h003;

  // oscillator_tuning fields
  localparam int TUNE_LFSRC_BIT = 7;
  localparam int TUNE_PLL_ENABLE_BIT_BIT = 6;
  localparam int TUNE_TRIM_LSB  = 0;
  localparam int TUNE_TRIM_W    = 6;

  // clock_config fields
  localparam int CFG_MODE_LSB  = 0;
  localparam int CFG_PRESC_LSB = 3;
  localparam int CFG_CPU_DIVIDE_SELECT_LSB = 6;
  localparam int CFG_LS48_BIT  = 8;
  localparam int CFG_PLLCF_BIT = 9;
  localparam int CFG_USBLS_BIT = 10;
  localparam int CFG_W         = 11;

  // reset values
  localparam logic [7:0]       TUNING_RST  = 8'h00;
  localparam logic [CFG_W-1:0] CONFIG_RST  = 11'h0c0;
  localparam logic [3:0]       FEATURE_RST = 4'h0;
  localparam logic [2:0]       IFS_RST     = 3'h6;

  typedef enum logic [2:0] {
    external_clock_mode,
    external_clock_pll_mode,
    crystal_mode,
    crystal_pll_mode,
    internal_fast_mode,
    internal_fast_pll_mode,
    internal_fast_pll_clkout_mode
  } ckt_mode_e;

  // cpu_divide_select codes
  localparam logic [1:0] CPU_DIVIDE_SELECT_BY1 = 2'b11;
  localparam logic [1:0] CPU_DIVIDE_SELECT_BY2 = 2'b10;
  localparam logic [1:0] CPU_DIVIDE_SELECT_BY3 = 2'b01;
  localparam logic [1:0] CPU_DIVIDE_SELECT_BY6 = 2'b00;

  // internal_freq_select codes
  localparam logic [2:0] IFS_FAST_DIRECT = 3'h7;
  localparam logic [2:0] IFS_LOW_FREQ    = 3'h0;

  // division ratios
  localparam logic [7:0] CLKOUT_RATIO = 8'h02;
  localparam logic [7:0] LS_RATIO_48  = 8'h08;
  localparam logic [7:0] LS_RATIO_24  = 8'h04;
  localparam logic [7:0] LFSRC_MASK   = 8'hff;

  // start-up counts: crystal settle in source edges, pll lock in reference ticks
  localparam logic [10:0] OST_EDGES     = 11'h400;
  localparam logic [3:0]  PLL_LOCK_REFS = 4'h8;

endpackage
`default_nettype wire

/* ckt_cfg_if.sv */
// configuration and status carried between register file and clock core
`timescale 1ns/10ps
`default_nettype none
interface ckt_cfg_if;
  import ckt_pkg::*;
  logic [7:0]       tuning;
  logic [CFG_W-1:0] config_word;
  logic [3:0]       feature;
  logic [2:0]       ifs;
  logic [7:0]       status;
  modport regs (output tuning, config_word, feature, ifs, input status);
  modport core (input tuning, config_word, feature, ifs, output status);
endinterface
`default_nettype wire

/* ckt_divider.sv */
// tick divider with a run-time ratio and a toggling level output
`timescale 1ns/10ps
`default_nettype none
module ckt_divider
  import ckt_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [7:0] ratio,
  input  wire logic       in_tick,
  output logic            out_tick,
  output logic            out_level
);
  logic [7:0] cnt_reg;
  logic       wrap;

  // a ratio lowered below the count wraps at once rather than running on
  assign wrap = (cnt_reg >= ratio - 8'h01);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_reg <= 8'h00;
    else if (in_tick)
      cnt_reg <= wrap ? 8'h00 : cnt_reg + 8'h01;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_tick  <= 1'b0;
      out_level <= 1'b0;
    end
    else
    begin
      out_tick <= in_tick & wrap;
      if (in_tick & wrap)
        out_level <= ~out_level;
    end
  end
endmodule
`default_nettype wire

/* ckt_regs.sv */
// ahb-lite register file of the clock tree
`timescale 1ns/10ps
`default_nettype none
module ckt_regs
  import ckt_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  ckt_cfg_if.regs          cfg
);
  logic        wr_pend_reg;
  logic [11:0] wr_idx_reg;
  logic        take;
  logic [11:0] idx;
  logic        in_map;

  // only whole-word transfers are decoded; other sizes are ignored
  assign take   = hsel & hready & htrans[1] & (hsize == 3'b010);
  assign idx    = haddr[13:2];
  assign in_map = (haddr[31:14] == 18'h0) & (haddr[1:0] == 2'b00);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 12'h000;
    end
    else
    begin
      wr_pend_reg <= take & hwrite & in_map;
      wr_idx_reg  <= idx;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg.tuning      <= TUNING_RST;
      cfg.config_word <= CONFIG_RST;
      cfg.feature     <= FEATURE_RST;
      cfg.ifs         <= IFS_RST;
    end
    else if (wr_pend_reg)
    begin
      if (wr_idx_reg == IDX_TUNING)
        cfg.tuning <= hwdata[7:0];
      else if (wr_idx_reg == IDX_CONFIG)
        cfg.config_word <= hwdata[CFG_W-1:0];
      else if (wr_idx_reg == IDX_FEATURE)
        cfg.feature <= hwdata[3:0];
      else if (wr_idx_reg == IDX_OSC_CTRL)
        cfg.ifs <= hwdata[2:0];
    end
  end

  // read data is captured at the address phase; zero wait states
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0;
    else if (take & ~hwrite & in_map)
    begin
      if (idx == IDX_TUNING)
        hrdata <= {24'h0, cfg.tuning};
      else if (idx == IDX_CONFIG)
        hrdata <= {21'h0, cfg.config_word};
      else if (idx == IDX_FEATURE)
        hrdata <= {28'h0, cfg.feature};
      else if (idx == IDX_OSC_CTRL)
        hrdata <= {29'h0, cfg.ifs};
      else if (idx == IDX_STATUS)
        hrdata <= {24'h0, cfg.status};
      else
        hrdata <= 32'h0;
    end
    else if (take & ~hwrite)
      hrdata <= 32'h0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* ckt_clock_tree.sv */
// clock tree core: source select, pll, cpu and usb dividers, clock out
`timescale 1ns/10ps
`default_nettype none
module ckt_clock_tree
  import ckt_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        clock_input_pin,
  input  wire logic        fast_osc_tick,
  input  wire logic        slow_rc_tick,
  output logic             clock_output_pin,
  output logic             core_clk_tick,
  output logic             usb_clk_tick,
  output logic             pll_running,
  output logic             slow_rc_run,
  output logic             clock_ready,
  output logic [5:0]       fast_osc_trim
);
  ckt_cfg_if cfg ();

  ckt_regs u_regs (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .cfg       (cfg)
  );

  ckt_mode_e   mode;
  logic [2:0]  presc_sel;
  logic [1:0]  cpu_divide_select;
  logic        ls48;
  logic        cfg_pll_en;
  logic        usb_ls;
  logic        tune_pll_enable_bit;
  logic        lfsrc;
  logic        pin_q_reg;
  logic        ext_tick;
  logic        is_ec;
  logic        is_xt;
  logic        is_int;
  logic        pll_mode_ok;
  logic        pll_on;
  logic        pll_src_tick;
  logic [7:0]  presc_ratio;
  logic        ref_tick;
  logic [3:0]  lock_cnt_reg;
  logic        sys_phase_reg;
  logic        sys_tick;
  logic [7:0]  cpu_ratio;
  logic        cpu_in;
  logic        cpu_tick;
  logic [7:0]  ls_ratio;
  logic        ls_in;
  logic        ls_tick;
  logic        co_in;
  logic        co_level;
  logic [7:0]  post_cnt_reg;
  logic [7:0]  post_mask;
  logic        int_tick;
  logic        use_slow;
  logic [10:0] ost_cnt_reg;

  assign mode       = ckt_mode_e'(cfg.config_word[CFG_MODE_LSB +: 3]);
  assign presc_sel  = cfg.config_word[CFG_PRESC_LSB +: 3];
  assign cpu_divide_select      = cfg.config_word[CFG_CPU_DIVIDE_SELECT_LSB +: 2];
  assign ls48       = cfg.config_word[CFG_LS48_BIT];
  assign cfg_pll_en = cfg.config_word[CFG_PLLCF_BIT];
  assign usb_ls     = cfg.config_word[CFG_USBLS_BIT];
  assign tune_pll_enable_bit = cfg.tuning[TUNE_PLL_ENABLE_BIT_BIT];
  assign lfsrc      = cfg.tuning[TUNE_LFSRC_BIT];

  // pin is synchronous; one flop is enough to find its rising edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pin_q_reg <= 1'b0;
    else
      pin_q_reg <= clock_input_pin;
  end

  assign ext_tick = clock_input_pin & ~pin_q_reg;

  assign is_ec  = (mode == external_clock_mode) |
                  (mode == external_clock_pll_mode);
  assign is_xt  = (mode == crystal_mode) | (mode == crystal_pll_mode);
  assign is_int = ~is_ec & ~is_xt;

  assign pll_mode_ok = (mode == crystal_pll_mode) |
                       (mode == external_clock_pll_mode) |
                       (mode == internal_fast_pll_mode) |
                       (mode == internal_fast_pll_clkout_mode);
  // config enable keeps the pll up whatever the tuning bit says
  assign pll_on = pll_mode_ok & (tune_pll_enable_bit | cfg_pll_en);

  assign pll_src_tick = is_int ? fast_osc_tick : ext_tick;

  // input must be a whole multiple of the pll reference frequency
  always_comb
  begin
    case (presc_sel)
      3'h0:    presc_ratio = 8'h01;
      3'h1:    presc_ratio = 8'h02;
      3'h2:    presc_ratio = 8'h03;
      3'h3:    presc_ratio = 8'h04;
      3'h4:    presc_ratio = 8'h05;
      3'h5:    presc_ratio = 8'h06;
      3'h6:    presc_ratio = 8'h0a;
      default: presc_ratio = 8'h0c;
    endcase
  end

  ckt_divider u_presc (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ratio     (presc_ratio),
    .in_tick   (pll_src_tick & pll_on),
    .out_tick  (ref_tick),
    .out_level ()
  );

  // lock is modelled as a number of reference ticks after turn-on
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lock_cnt_reg <= 4'h0;
    else if (!pll_on)
      lock_cnt_reg <= 4'h0;
    else if (ref_tick & (lock_cnt_reg != PLL_LOCK_REFS))
      lock_cnt_reg <= lock_cnt_reg + 4'h1;
  end

  // every hclk edge stands in for one 96 MHz pll edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pll_running   <= 1'b0;
      sys_phase_reg <= 1'b0;
    end
    else
    begin
      pll_running   <= pll_on & (lock_cnt_reg == PLL_LOCK_REFS);
      sys_phase_reg <= pll_running & ~sys_phase_reg;
    end
  end

  // system clock is the pll output halved
  assign sys_tick = pll_running & sys_phase_reg;

  always_comb
  begin
    case (cpu_divide_select)
      CPU_DIVIDE_SELECT_BY1: cpu_ratio = 8'h01;
      CPU_DIVIDE_SELECT_BY2: cpu_ratio = 8'h02;
      CPU_DIVIDE_SELECT_BY3: cpu_ratio = 8'h03;
      default:   cpu_ratio = 8'h06;
    endcase
  end

  assign cpu_in = pll_running ? sys_tick : ext_tick;

  ckt_divider u_cpu (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ratio     (cpu_ratio),
    .in_tick   (cpu_in),
    .out_tick  (cpu_tick),
    .out_level ()
  );

  assign ls_ratio = ls48 ? LS_RATIO_48 : LS_RATIO_24;
  assign ls_in    = pll_running ? sys_tick : ext_tick;

  ckt_divider u_usb_ls (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ratio     (ls_ratio),
    .in_tick   (ls_in),
    .out_tick  (ls_tick),
    .out_level ()
  );

  // the level toggles every second edge, so the pin shows source over 4, or pll over 4 in external_clock_pll_mode
  assign co_in = (mode == external_clock_mode) ? ext_tick :
                 (mode == external_clock_pll_mode) & pll_running;

  ckt_divider u_clkout (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ratio     (CLKOUT_RATIO),
    .in_tick   (co_in),
    .out_tick  (),
    .out_level (co_level)
  );

  // postscaler of the fast oscillator; the mask sets the ratio
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      post_cnt_reg <= 8'h00;
    else if (fast_osc_tick)
      post_cnt_reg <= post_cnt_reg + 8'h01;
  end

  assign post_mask = (cfg.ifs == IFS_LOW_FREQ) ? LFSRC_MASK :
                     (LFSRC_MASK >> (cfg.ifs + 3'h1));
  assign use_slow  = (cfg.ifs == IFS_LOW_FREQ) & ~lfsrc;

  always_comb
  begin
    if (cfg.ifs == IFS_FAST_DIRECT)
      int_tick = fast_osc_tick;
    else if (use_slow)
      int_tick = slow_rc_tick;
    else
      int_tick = fast_osc_tick &
                 ((post_cnt_reg & post_mask) == post_mask);
  end

  // core clock falls back to the primary source until pll lock; full-speed usb gets no ticks until then
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      core_clk_tick <= 1'b0;
      usb_clk_tick  <= 1'b0;
    end
    else
    begin
      if (pll_running)
        core_clk_tick <= cpu_tick;
      else
        core_clk_tick <= is_int ? int_tick : cpu_tick;
      usb_clk_tick <= usb_ls ? ls_tick : sys_tick;
    end
  end

  // external clock needs no start-up wait; a crystal must settle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ost_cnt_reg <= 11'h000;
    else if (!is_xt)
      ost_cnt_reg <= 11'h000;
    else if (ext_tick & (ost_cnt_reg != OST_EDGES))
      ost_cnt_reg <= ost_cnt_reg + 11'h001;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clock_ready      <= 1'b0;
      clock_output_pin <= 1'b0;
      slow_rc_run      <= 1'b0;
      fast_osc_trim    <= 6'h00;
    end
    else
    begin
      clock_ready <= is_ec | is_int |
                     (ost_cnt_reg == OST_EDGES);
      clock_output_pin <= is_ec & co_level;
      slow_rc_run <= (is_int & use_slow) | (|cfg.feature);
      fast_osc_trim <= cfg.tuning[TUNE_TRIM_LSB +: TUNE_TRIM_W];
    end
  end

  assign cfg.status = {2'b00, mode, slow_rc_run, clock_ready,
                       pll_running};

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // the release edge itself is left out: ready is still low there
  sequence ec_steady_s;
    (hresetn & is_ec) [*2];
  endsequence

  sequence external_clock_pll_mode_steady_s;
    ((mode == external_clock_pll_mode) & pll_running) [*8];
  endsequence

  ec_ready_a: assert property (ec_steady_s |-> clock_ready)
    else $error("external clock mode not ready at once");

  clkout_off_a: assert property (!is_ec [*3] |-> !clock_output_pin)
    else $error("clock out driven outside external modes");

  clkout_pll_a: assert property (external_clock_pll_mode_steady_s |->
    clock_output_pin != $past(clock_output_pin, 2))
    else $error("clock out not pll over four");

  pll_gate_a: assert property (pll_running |-> $past(pll_mode_ok))
    else $error("pll running outside a pll mode");

  pll_hold_a: assert property ((cfg_pll_en & pll_mode_ok) |-> pll_on)
    else $error("tuning clear turned the pll off");

  presc_map_a: assert property ((presc_sel == 3'h2) |->
    presc_ratio == 8'h03)
    else $error("prescale code 2 is not divide by three");

  cpu_divide_select_map_a: assert property ((cpu_divide_select == CPU_DIVIDE_SELECT_BY6) |->
    cpu_ratio == 8'h06)
    else $error("divide select 00 is not divide by six");

  ls_ratio_a: assert property (ls48 |-> ls_ratio == 8'h08)
    else $error("low speed source 1 not divide by eight");

  slow_rc_a: assert property ((|cfg.feature) |=> slow_rc_run)
    else $error("slow rc not running for an enabled feature");

  int_direct_a: assert property ((is_int & ~pll_running &
    (cfg.ifs == IFS_FAST_DIRECT) & fast_osc_tick) |=> core_clk_tick)
    else $error("fast direct tick not passed to core");

  usb_fs_a: assert property ((~usb_ls & sys_tick) |=> usb_clk_tick)
    else $error("full speed usb tick missing");
endmodule
`default_nettype wire

/* ckt_ext_clk_src.sv */
// model of the outside party: a driven square wave on the clock input pin
`timescale 1ns/10ps
`default_nettype none
module ckt_ext_clk_src (
  input  wire logic       hclk,
  input  wire logic [7:0] half_cycles,
  output logic            clk_out
);
  int cnt = 0;

  initial clk_out = 1'b0;

  // free running, like a real oscillator; a driven level, never a crystal
  always @(posedge hclk)
  begin
    if (cnt + 1 >= int'(half_cycles))
    begin
      cnt <= 0;
      clk_out <= ~clk_out;
    end
    else
      cnt <= cnt + 1;
  end
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking testbench for the clock tree block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ckt_pkg::*;
  localparam logic [31:0] A_TUNE = {18'h0, IDX_TUNING, 2'b00};
  localparam logic [31:0] A_CFG  = {18'h0, IDX_CONFIG, 2'b00};
  localparam logic [31:0] A_FEAT = {18'h0, IDX_FEATURE, 2'b00};
  localparam logic [31:0] A_OSC  = {18'h0, IDX_OSC_CTRL, 2'b00};
  localparam logic [31:0] A_STAT = {18'h0, IDX_STATUS, 2'b00};
  logic        hclk      = 1'b0;
  logic        hresetn   = 1'b0;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [2:0]  hsize     = 3'h2;
  logic [31:0] hwdata    = 32'h0;
  logic        fast_tick = 1'b0;
  logic        slow_tick = 1'b0;
  logic [7:0]  half      = 8'h01;
  logic [3:0]  tick_cnt  = 4'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        ext_clk;
  logic        clk_out;
  logic        core_tick;
  logic        usb_tick;
  logic        pll_on;
  logic        rc_run;
  logic        clk_rdy;
  logic [5:0]  trim;
  logic [31:0] rd;
  logic [31:0] d;
  int          fails       = 0;
  int          check_count = 0;
  int          c;
  int          i;
  int          ratio[8]    = '{1, 2, 3, 4, 5, 6, 10, 12};
  int          divs[4]     = '{1, 2, 3, 6};

  always #4 hclk = ~hclk;

  // stand-ins for the on-chip oscillators: fast every 4, slow every 16
  always @(posedge hclk)
  begin
    tick_cnt <= tick_cnt + 4'h1;
    fast_tick <= (tick_cnt[1:0] == 2'h3);
    slow_tick <= (tick_cnt == 4'hf);
  end

  ckt_ext_clk_src u_ckt_ext_clk_src (
    .hclk        (hclk),
    .half_cycles (half),
    .clk_out     (ext_clk)
  );

  ckt_clock_tree u_ckt_clock_tree (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (hsize),
    .hwdata           (hwdata),
    .hready           (hreadyout),
    .hrdata           (hrdata),
    .hreadyout        (hreadyout),
    .hresp            (hresp),
    .clock_input_pin  (ext_clk),
    .fast_osc_tick    (fast_tick),
    .slow_rc_tick     (slow_tick),
    .clock_output_pin (clk_out),
    .core_clk_tick    (core_tick),
    .usb_clk_tick     (usb_tick),
    .pll_running      (pll_on),
    .slow_rc_run      (rc_run),
    .clock_ready      (clk_rdy),
    .fast_osc_trim    (trim)
  );

  task automatic stop_test();
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // counts drift by a tick or two with divider phase, so allow a margin
  function automatic logic [31:0] near(input int seen, input int exp,
                                       input int tol);
    return (seen >= exp - tol && seen <= exp + tol) ? exp : seen;
  endfunction

  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    ahb(1'b1, a, wd, rd);
  endtask

  task automatic rdchk(input string name, input logic [31:0] a,
                       input logic [31:0] exp);
    ahb(1'b0, a, 32'h0, rd);
    check(name, rd, exp);
    check("hresp", hresp, 1'b0);
    check("hreadyout", hreadyout, 1'b1);
  endtask

  // sel 0: rises of clock out, 1: core ticks, 2: usb ticks
  task automatic count(input int sel, input int n, output int cnt);
    logic prev;
    logic s;
    cnt = 0;
    prev = clk_out;
    repeat (n)
    begin
      @(posedge hclk);
      s = (sel == 0) ? clk_out : (sel == 1) ? core_tick : usb_tick;
      if (s === 1'b1 && (sel != 0 || prev === 1'b0))
        cnt++;
      prev = s;
    end
  endtask

  task automatic wait_pll(output int n);
    n = 0;
    while (pll_on !== 1'b1 && n < 2000)
    begin
      @(posedge hclk);
      n++;
    end
  endtask

  initial
  begin
    d = $urandom(77256);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    check("clock_ready", clk_rdy, 1'b1);
    check("pll_running", pll_on, 1'b0);
    rdchk("tuning", A_TUNE, 32'h0);
    rdchk("config", A_CFG, 32'h0c0);
    rdchk("feature", A_FEAT, 32'h0);
    rdchk("osc_ctrl", A_OSC, 32'h6);
    rdchk("status", A_STAT, 32'h2);
    wr(32'h10, 32'hff);
    rdchk("unmapped", 32'h10, 32'h0);
    wr(A_STAT, 32'hff);
    rdchk("status_ro", A_STAT, 32'h2);
    for (i = 0; i < 6; i++)
    begin
      d = $urandom();
      wr(A_TUNE, d);
      rdchk("tuning_rw", A_TUNE, {24'h0, d[7:0]});
      check("trim", trim, d[5:0]);
    end
    wr(A_TUNE, 32'h0);
    half <= 8'h02;
    count(0, 320, c);
    check("clkout_ext", near(c, 20, 2), 20);
    half <= 8'h01;
    wr(A_CFG, 32'h4c0);
    count(2, 96, c);
    check("usb_ls_osc4", near(c, 12, 2), 12);
    wr(A_CFG, 32'h5c0);
    count(2, 96, c);
    check("usb_ls_osc8", near(c, 6, 2), 6);
    wr(A_TUNE, 32'h40);
    repeat (300) @(posedge hclk);
    check("pll_ext_mode", pll_on, 1'b0);
    for (i = 0; i < 8; i++)
    begin
      wr(A_TUNE, 32'h0);
      wr(A_CFG, 32'h0c1 | (i << 3));
      repeat (4) @(posedge hclk);
      check("pll_disabled", pll_on, 1'b0);
      wr(A_TUNE, 32'h40);
      wait_pll(c);
      check("lock_time", near(c, 16 * ratio[i], 2 * ratio[i] + 4),
            16 * ratio[i]);
    end
    count(0, 200, c);
    check("clkout_pll", near(c, 50, 2), 50);
    for (i = 0; i < 4; i++)
    begin
      wr(A_CFG, 32'h039 | ((3 - i) << 6));
      wait_pll(c);
      count(1, 120, c);
      check("core_div", near(c, 60 / divs[i], 2), 60 / divs[i]);
    end
    wr(A_CFG, 32'h539);
    count(2, 96, c);
    check("usb_ls48", near(c, 6, 2), 6);
    wr(A_CFG, 32'h439);
    count(2, 96, c);
    check("usb_ls24", near(c, 12, 2), 12);
    wr(A_CFG, 32'h039);
    count(2, 96, c);
    check("usb_fs", near(c, 48, 2), 48);
    wr(A_CFG, 32'h239);
    wr(A_TUNE, 32'h0);
    repeat (300) @(posedge hclk);
    check("cfg_pll_hold", pll_on, 1'b1);
    wr(A_CFG, 32'h039);
    repeat (8) @(posedge hclk);
    check("pll_both_clear", pll_on, 1'b0);
    for (i = 0; i < 4; i++)
    begin
      wr(A_FEAT, 32'h1 << i);
      repeat (3) @(posedge hclk);
      check("rc_feature", rc_run, 1'b1);
    end
    wr(A_FEAT, 32'h0);
    repeat (3) @(posedge hclk);
    check("rc_idle", rc_run, 1'b0);
    wr(A_CFG, 32'h0c4);
    for (i = 7; i > 0; i--)
    begin
      wr(A_OSC, i);
      count(1, 512, c);
      check("int_fast", near(c, 128 >> (7 - i), 2), 128 >> (7 - i));
    end
    wr(A_OSC, 32'h0);
    count(1, 512, c);
    check("int_slow", near(c, 32, 2), 32);
    check("rc_selected", rc_run, 1'b1);
    wr(A_CFG, 32'h0c5);
    wr(A_TUNE, 32'h40);
    wait_pll(c);
    check("lock_int", near(c, 32, 6), 32);
    count(1, 120, c);
    check("core_int_pll", near(c, 60, 2), 60);
    wr(A_CFG, 32'h0c2);
    repeat (4) @(posedge hclk);
    check("pll_crystal", pll_on, 1'b0);
    check("xtal_wait", clk_rdy, 1'b0);
    repeat (2100) @(posedge hclk);
    check("xtal_ready", clk_rdy, 1'b1);
    stop_test();
  end

  // the whole sequence needs about ten thousand cycles
  initial
  begin
    repeat (40000) @(posedge hclk);
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire
